// >>> rss_pkg.sv
// rss_pkg: shared constants and types for the serial access block
package rss_pkg;

  // ************************************************************
  // address map
  // ************************************************************
  localparam int          ADDR_W          = 7;
  localparam int          MEM_BYTES       = 96;
  localparam logic [6:0]  REG_BASE        = 7'h00;
  localparam logic [6:0]  REG_LAST        = 7'h1f;
  localparam logic [6:0]  SRAM_BASE       = 7'h20;
  localparam logic [6:0]  SRAM_LAST       = 7'h5f;
  localparam logic [6:0]  FLAG_REG        = 7'h03;
  localparam int          FLAG_BIT        = 4;
  localparam logic [6:0]  TS_LOSS_BASE    = 7'h18;
  localparam logic [6:0]  TS_RESTORE_BASE = 7'h1c;
  localparam int          TS_BYTES        = 4;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;

  // ************************************************************
  // bus framing
  // ************************************************************
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [6:0]  DEV_ADDR_DEF    = 7'h5a;
  localparam int          FIFO_DEPTH      = 16;

  // ************************************************************
  // types
  // ************************************************************
  typedef logic [TS_BYTES-1:0][7:0] rss_time_type;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } rss_wr_req_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WORD,
    ST_WORD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK
  } rss_state_type;

endpackage

// >>> rss_fifo.sv
// rss_fifo: flop-based valid/ready fifo with parameterised width and depth
module rss_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  wire              push    = in_valid & in_ready;
  wire              pop     = out_valid & out_ready;
  wire  [PW-1:0]    wr_last = PW'(DEPTH - 1);

  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = store_r[rd_ptr_r];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      store_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == wr_last) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == wr_last) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// >>> rss_serial_access.sv
// rss_serial_access: two-wire slave access to clock registers and user sram with time-stamps
module rss_serial_access
  import rss_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = rss_pkg::DEV_ADDR_DEF  // arbitrary value
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // two-wire bus
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // supply and timekeeping
  input  wire logic                  main_supply_ok,
  input  wire logic                  backup_present,
  input  wire logic                  osc_running,
  input  wire logic                  rtc_update_busy,
  input  wire rss_pkg::rss_time_type cur_time,
  // status
  output logic                       on_backup
);

  import rss_pkg::*;

  // ************************************************************
  // pointer wrap
  // ************************************************************
  function automatic logic [6:0] next_addr(input logic [6:0] a);
    logic [6:0] n;
    n = a + 7'h01;
    if (a == SRAM_LAST) begin
      n = SRAM_BASE;
    end else if (a == REG_LAST) begin
      n = REG_BASE;
    end
    return n;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  rss_state_type  state_r;
  logic [3:0]     bitcnt_r;
  logic [7:0]     rx_r;
  logic [7:0]     tx_r;
  logic [6:0]     ptr_r;
  logic           more_r;
  logic           scl_r;
  logic           sda_r;
  logic           sda_oe_r;
  logic           main_ok_r;
  logic [7:0]     mem_r [MEM_BYTES];

  rss_wr_req_type push_req;
  rss_wr_req_type head_req;
  logic           push_ready;
  logic           head_valid;

  // ************************************************************
  // bus event decode
  // ************************************************************
  wire scl_rise   = scl_in & ~scl_r;
  wire scl_fall   = ~scl_in & scl_r;
  wire bus_start  = scl_in & scl_r & sda_r & ~sda_in;
  wire bus_stop   = scl_in & scl_r & ~sda_r & sda_in;
  wire byte_done  = scl_fall & (bitcnt_r == BITS_PER_BYTE);
  wire addr_match = (rx_r[7:1] == DEV_ADDR);
  wire addr_read  = rx_r[0];
  wire word_ok    = (rx_r <= {1'b0, SRAM_LAST});
  wire rx_state   = (state_r == ST_ADDR) | (state_r == ST_WORD) | (state_r == ST_WDATA);
  wire [7:0] rd_byte = mem_r[ptr_r];

  // ************************************************************
  // write path through the fifo
  // ************************************************************
  wire wdata_done = byte_done & (state_r == ST_WDATA);
  wire push_valid = wdata_done;
  wire head_reg   = (head_req.addr < SRAM_BASE);
  // only clock registers wait for an update; an sram write at the head drains at once
  wire drain_rdy  = ~(rtc_update_busy & head_reg);
  wire drain      = head_valid & drain_rdy;

  assign push_req = rss_wr_req_type'{addr: ptr_r, data: rx_r};

  rss_fifo #(
    .WIDTH ($bits(rss_wr_req_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_req),
    .out_valid (head_valid),
    .out_ready (drain_rdy),
    .out_data  (head_req)
  );

  // ************************************************************
  // supply events
  // ************************************************************
  wire cap_ok      = backup_present & osc_running;
  wire supply_loss = main_ok_r & ~main_supply_ok & cap_ok;
  wire supply_back = ~main_ok_r & main_supply_ok & cap_ok;
  wire flag_clear  = drain & (head_req.addr == FLAG_REG) & ~head_req.data[FLAG_BIT]
                     & mem_r[FLAG_REG][FLAG_BIT];

  // ************************************************************
  // storage
  // ************************************************************
  // sram bytes carry no reset and survive loss of main supply
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < int'(SRAM_BASE); i++) begin
        mem_r[i] <= REG_RESET_VAL;  // only registers reset
      end
    end else begin
      if (drain) begin
        mem_r[head_req.addr] <= head_req.data;
      end
      if (flag_clear) begin
        for (int i = 0; i < 2*TS_BYTES; i++) begin
          mem_r[TS_LOSS_BASE + 7'(i)] <= REG_RESET_VAL;
        end
      end
      // captures come last so a set beats a clear in the same cycle
      if (supply_loss) begin
        for (int i = 0; i < TS_BYTES; i++) begin
          mem_r[TS_LOSS_BASE + 7'(i)] <= cur_time[i];
        end
        mem_r[FLAG_REG][FLAG_BIT] <= 1'b1;
      end
      if (supply_back) begin
        for (int i = 0; i < TS_BYTES; i++) begin
          mem_r[TS_RESTORE_BASE + 7'(i)] <= cur_time[i];
        end
      end
    end
  end

  assign on_backup = mem_r[FLAG_REG][FLAG_BIT];
  assign sda_out   = 1'b0;
  assign sda_oe    = sda_oe_r;

  // ************************************************************
  // bus sampling
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_r     <= 1'b1;
      sda_r     <= 1'b1;
      main_ok_r <= 1'b0;
    end else begin
      scl_r     <= scl_in;
      sda_r     <= sda_in;
      main_ok_r <= main_supply_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_r     <= 8'h00;
      bitcnt_r <= 4'h0;
      more_r   <= 1'b0;
    end else begin
      if (bus_start | byte_done | (scl_fall & (state_r == ST_ADDR_ACK | state_r == ST_WORD_ACK
          | state_r == ST_WDATA_ACK | state_r == ST_RACK))) begin
        bitcnt_r <= 4'h0;
      end else if (scl_rise & (rx_state | state_r == ST_RDATA)) begin
        bitcnt_r <= bitcnt_r + 4'h1;
      end
      if (scl_rise & rx_state) begin
        rx_r <= {rx_r[6:0], sda_in};
      end
      if (scl_rise & (state_r == ST_RACK)) begin
        more_r <= ~sda_in;
      end
    end
  end

  // ************************************************************
  // protocol state machine
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
      tx_r     <= 8'h00;
      ptr_r    <= REG_BASE;
    end else if (~main_supply_ok) begin
      state_r  <= ST_IDLE;  // no bus access on backup
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      state_r  <= ST_ADDR;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: begin
          if (byte_done & addr_match) begin
            state_r  <= ST_ADDR_ACK;
            sda_oe_r <= 1'b1;
            if (addr_read) begin
              tx_r  <= rd_byte;
              ptr_r <= next_addr(ptr_r);
            end
          end else if (byte_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (tx_valid_dir()) begin
            state_r  <= ST_RDATA;
            sda_oe_r <= ~tx_r[7];
          end else begin
            state_r  <= ST_WORD;
            sda_oe_r <= 1'b0;
          end
        end
        ST_WORD: begin
          if (byte_done & word_ok) begin
            ptr_r    <= rx_r[6:0];  // latched before any restart
            state_r  <= ST_WORD_ACK;
            sda_oe_r <= 1'b1;
          end else if (byte_done) begin
            state_r  <= ST_IDLE;
          end
        end
        ST_WORD_ACK: begin
          state_r  <= ST_WDATA;
          sda_oe_r <= 1'b0;
        end
        ST_WDATA: begin
          if (byte_done & push_ready) begin
            ptr_r    <= next_addr(ptr_r);
            state_r  <= ST_WDATA_ACK;
            sda_oe_r <= 1'b1;
          end else if (byte_done) begin
            state_r  <= ST_IDLE;  // full fifo answers with nack
          end
        end
        ST_WDATA_ACK: begin
          state_r  <= ST_WDATA;
          sda_oe_r <= 1'b0;
        end
        ST_RDATA: begin
          if (bitcnt_r == BITS_PER_BYTE) begin
            state_r  <= ST_RACK;
            sda_oe_r <= 1'b0;
          end else begin
            tx_r     <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        end
        ST_RACK: begin
          if (more_r) begin
            tx_r     <= rd_byte;
            ptr_r    <= next_addr(ptr_r);
            sda_oe_r <= ~rd_byte[7];
            state_r  <= ST_RDATA;
          end else begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // direction of the transfer, kept in the address shift register
  function automatic logic tx_valid_dir();
    return rx_r[0];
  endfunction

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_LOSS_CAPTURE: assert property (supply_loss |=> mem_r[TS_LOSS_BASE] == $past(cur_time[0])
    && mem_r[TS_LOSS_BASE + 7'h3] == $past(cur_time[3]))
    else $error("loss time-stamp not captured");
  AST_LOSS_FLAG: assert property (supply_loss |=> on_backup)
    else $error("battery-mode flag not set on supply loss");
  AST_RESTORE_CAPTURE: assert property (supply_back |=> mem_r[TS_RESTORE_BASE] == $past(cur_time[0]))
    else $error("restore time-stamp not captured");
  AST_FLAG_CLEAR: assert property (flag_clear && !supply_loss && !supply_back |=>
    mem_r[TS_LOSS_BASE] == 8'h00 && mem_r[TS_RESTORE_BASE + 7'h3] == 8'h00 && !on_backup)
    else $error("time-stamps not cleared with flag");
  AST_NO_CAPTURE: assert property (main_ok_r && !main_supply_ok && !cap_ok && !drain
    |=> $stable(mem_r[TS_LOSS_BASE]) && $stable(on_backup))
    else $error("capture without backup or oscillator");
  AST_SRAM_DRAIN: assert property (head_valid && !head_reg |=> mem_r[$past(head_req.addr)] == $past(head_req.data))
    else $error("sram write stalled");
  AST_BAD_WORD_NACK: assert property (byte_done && state_r == ST_WORD && !word_ok && main_supply_ok
    && !bus_start && !bus_stop |=> !sda_oe_r && state_r == ST_IDLE)
    else $error("bad word address acknowledged");
  AST_ADDR_ACK: assert property (byte_done && state_r == ST_ADDR && addr_match && main_supply_ok
    && !bus_start && !bus_stop |=> sda_oe_r ##1 (sda_oe_r || state_r != ST_ADDR_ACK))
    else $error("control byte not acknowledged");
  AST_PTR_WRITE: assert property (push_valid && push_ready && state_r == ST_WDATA && main_supply_ok
    && !bus_start && !bus_stop |=> ptr_r == next_addr($past(ptr_r)))
    else $error("pointer not advanced after write");
  AST_SRAM_WRAP: assert property ($past(ptr_r) == SRAM_LAST && $changed(ptr_r)
    && $past(state_r) != ST_WORD |-> ptr_r == SRAM_BASE)
    else $error("sram pointer did not wrap to base");
  AST_PTR_RANGE: assert property (ptr_r <= SRAM_LAST)
    else $error("pointer outside map");

  COV_WRITE: cover property (push_valid && push_ready && state_r == ST_WDATA);
  COV_SEQ_READ: cover property (scl_fall && state_r == ST_RACK && more_r);
  COV_LOSS: cover property (supply_loss);
  COV_CLEAR: cover property (flag_clear);

endmodule

// >>> rss_master_model.sv
// rss_master_model: two-wire bus master that drives the serial access block
module rss_master_model #(
  parameter int Q = 4
) (
  // clock
  input  wire logic sys_clk,
  // bus
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic q_wait();
    repeat (Q) @(negedge sys_clk);
  endtask

  // also serves as repeated start: sda released while scl is low
  task automatic start();
    sda_low = 1'b0;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    q_wait();
    scl = 1'b1;
    q_wait();
    sda_low = 1'b0;
    q_wait();
  endtask

  // data only moves while scl is low; the line is read mid-high
  task automatic put_bit(input logic b, output logic seen);
    sda_low = ~b;
    q_wait();
    scl = 1'b1;
    q_wait();
    seen = sda;
    q_wait();
    scl = 1'b0;
    q_wait();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~ack, s);
  endtask
endmodule

// >>> test_rtcc_sram_serial_access.sv
// test_rtcc_sram_serial_access: self-checking bench for the serial access block
module test_rtcc_sram_serial_access;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;

  logic         sys_clk;
  logic         rst;
  logic         scl;
  logic         sda_low;
  logic         sda_out;
  logic         sda_oe;
  wire logic    sda_line;
  logic         main_supply_ok;
  logic         backup_present;
  logic         osc_running;
  logic         rtc_update_busy;
  rss_time_type cur_time;
  rss_time_type t0;
  rss_time_type t1;
  logic         on_backup;
  logic [7:0]   wbuf [20];
  logic [7:0]   rbuf [20];
  logic [7:0]   e1;
  logic [7:0]   e2;
  logic [6:0]   a;
  logic         nk;
  int           acks;
  int           failures;
  int           tests_run;

  // ************************************************************
  // bus wiring and instances
  // ************************************************************
  // pull-up: high unless a party pulls low
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  rss_serial_access #(
    .DEV_ADDR (DEV_ADDR_DEF)
  ) i_rss_serial_access (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .scl_in          (scl),
    .sda_in          (sda_line),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .main_supply_ok  (main_supply_ok),
    .backup_present  (backup_present),
    .osc_running     (osc_running),
    .rtc_update_busy (rtc_update_busy),
    .cur_time        (cur_time),
    .on_backup       (on_backup)
  );

  rss_master_model i_rss_master_model (
    .sys_clk (sys_clk),
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda_line)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [6:0] nxt(input logic [6:0] p);
    if (p == SRAM_LAST)
      return SRAM_BASE;
    if (p == REG_LAST)
      return REG_BASE;
    return p + 7'h01;
  endfunction

  task automatic set_ptr(input logic [6:0] p, output logic ack);
    logic k;
    i_rss_master_model.start();
    i_rss_master_model.wr_byte({DEV_ADDR_DEF, 1'b0}, k);
    i_rss_master_model.wr_byte({1'b0, p}, ack);
  endtask

  task automatic wr_seq(input logic [6:0] p, input int n, output int cnt);
    logic k;
    set_ptr(p, k);
    cnt = (k === 1'b1) ? 2 : 0;
    for (int i = 0; i < n && k === 1'b1; i++) begin
      i_rss_master_model.wr_byte(wbuf[i], k);
      cnt += (k === 1'b1) ? 1 : 0;
    end
    i_rss_master_model.stop();
  endtask

  task automatic rd_seq(input logic [6:0] p, input logic rnd, input int n);
    logic k;
    if (rnd)
      set_ptr(p, k);
    i_rss_master_model.start();
    i_rss_master_model.wr_byte({DEV_ADDR_DEF, 1'b1}, k);
    check(8'(k), 8'h01);
    for (int i = 0; i < n; i++)
      i_rss_master_model.rd_byte(i < n - 1, rbuf[i]);
    i_rss_master_model.stop();
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    repeat (80000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    main_supply_ok = 1'b1;
    backup_present = 1'b1;
    osc_running = 1'b1;
    rtc_update_busy = 1'b0;
    cur_time = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(8));
    cyc(20);
    rst = 1'b0;
    cyc(2);
    for (int it = 0; it < 4; it++) begin
      a = (it == 0) ? SRAM_LAST : SRAM_BASE + 7'($urandom_range(63, 0));
      rtc_update_busy = (it == 0) ? 1'b1 : 1'($urandom_range(1, 0));
      for (int i = 0; i < 3; i++)
        wbuf[i] = 8'($urandom());
      e1 = wbuf[1];
      e2 = wbuf[2];
      wr_seq(a, 3, acks);
      check(8'(acks), 8'h05);
      wbuf[0] = 8'($urandom());
      wr_seq(a, 1, acks);
      rd_seq(a, 1'b0, 2);
      check(rbuf[0], e1);
      check(rbuf[1], e2);
      rd_seq(a, 1'b1, 1);
      check(rbuf[0], wbuf[0]);
      rd_seq(a, 1'b0, 1);
      check(rbuf[0], e1);
    end
    $display("test sram access done");
    rtc_update_busy = 1'b0;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 7'h60 : (i == 1) ? 7'h7f : 7'($urandom_range(127, 96));
      wr_seq(a, 1, acks);
      check(8'(acks), 8'h00);
    end
    // a foreign control code must be left unanswered
    i_rss_master_model.start();
    i_rss_master_model.wr_byte({DEV_ADDR_DEF ^ 7'h01, 1'b0}, nk);
    i_rss_master_model.stop();
    check(8'(nk), 8'h00);
    $display("test address limit done");
    wbuf[0] = 8'($urandom());
    wbuf[1] = 8'($urandom());
    wr_seq(REG_LAST, 2, acks);
    rd_seq(REG_LAST, 1'b1, 2);
    check(rbuf[0], wbuf[0]);
    check(rbuf[1], wbuf[1]);
    rd_seq(nxt(REG_LAST), 1'b1, 1);
    check(rbuf[0], wbuf[1]);
    $display("test register wrap done");
    // clock update stalls register writes, so the fifo fills
    rtc_update_busy = 1'b1;
    for (int i = 0; i <= FIFO_DEPTH; i++)
      wbuf[i] = 8'($urandom()) & 8'hef;
    wr_seq(REG_BASE, FIFO_DEPTH + 1, acks);
    check(8'(acks), 8'(FIFO_DEPTH + 2));
    rtc_update_busy = 1'b0;
    cyc(40);
    rd_seq(REG_BASE, 1'b1, FIFO_DEPTH);
    for (int i = 0; i < FIFO_DEPTH; i++)
      check(rbuf[i], wbuf[i]);
    $display("test fifo fill done");
    wbuf[0] = 8'($urandom());
    wr_seq(SRAM_BASE, 1, acks);
    t0 = rss_time_type'($urandom());
    t1 = rss_time_type'($urandom());
    cur_time = t0;
    cyc(2);
    main_supply_ok = 1'b0;
    cyc(4);
    check(8'(on_backup), 8'h01);
    cur_time = t1;
    cyc(4);
    main_supply_ok = 1'b1;
    cyc(4);
    rd_seq(TS_LOSS_BASE, 1'b1, 2 * TS_BYTES);
    for (int i = 0; i < TS_BYTES; i++) begin
      check(rbuf[i], t0[i]);
      check(rbuf[i + TS_BYTES], t1[i]);
    end
    rd_seq(FLAG_REG, 1'b1, 1);
    check(8'(rbuf[0][FLAG_BIT]), 8'h01);
    rd_seq(SRAM_BASE, 1'b1, 1);
    check(rbuf[0], wbuf[0]);
    $display("test supply events done");
    wbuf[0] = 8'h00;
    wr_seq(FLAG_REG, 1, acks);
    cyc(4);
    check(8'(on_backup), 8'h00);
    rd_seq(TS_LOSS_BASE, 1'b1, 2 * TS_BYTES);
    for (int i = 0; i < 2 * TS_BYTES; i++)
      check(rbuf[i], 8'h00);
    $display("test flag clear done");
    for (int g = 0; g < 2; g++) begin
      backup_present = (g != 0);
      osc_running = (g == 0);
      cur_time = rss_time_type'($urandom());
      main_supply_ok = 1'b0;
      cyc(6);
      check(8'(on_backup), 8'h00);
      main_supply_ok = 1'b1;
      cyc(4);
      rd_seq(TS_LOSS_BASE, 1'b1, 2 * TS_BYTES);
      for (int i = 0; i < 2 * TS_BYTES; i++)
        check(rbuf[i], 8'h00);
    end
    $display("test capture gating done");
    tally_and_finish();
  end
endmodule
